// [hdl/psc_defs.svh]
`ifndef PSC_DEFS_SVH
`define PSC_DEFS_SVH
`define PSC_CLK_PERIOD_NS 10
`define PSC_BIT_PERIOD_NS 1000
`define PSC_BIT_CYCLES (`PSC_BIT_PERIOD_NS / `PSC_CLK_PERIOD_NS)
`define PSC_DECIM 48
`define PSC_SINC_W 23
`define PSC_DATA_W 32
`define PSC_SIG_BITS 18
`define PSC_SEL_W 4
`define PSC_COEF_FRAC 22
`define PSC_NUM_SETS 4
`endif

// [hdl/psc_pkg.sv]
package psc_pkg;
  typedef struct packed {
    logic signed [23:0] a0;
    logic signed [23:0] n1, n2, n3, d2, d3;
    logic signed [23:0] m1, m2, m3, e2, e3;
  } psc_coef_t;
  typedef struct packed {
    logic signed [31:0] p0, pp, ppp, pppp, pt, ptt, ppt;
  } psc_trim_t;
  typedef struct packed {
    logic signed [31:0] ofs;
    logic signed [31:0] gain;
    logic [3:0]         lowpass_coeff_select;
  } psc_user_t;
  typedef enum logic [1:0] {
    PSC_IDLE = 2'b00, PSC_TRIM = 2'b01, PSC_LPF = 2'b10, PSC_OUT = 2'b11
  } psc_state_t;
endpackage : psc_pkg

// [hdl/psc_coef_rom.sv]
`timescale 1ns/1ps
`default_nettype none
`include "psc_defs.svh"
module psc_coef_rom
  import psc_pkg::*;
(
  input  wire logic        ref_clk_in,
  input  wire logic        rst_n_in,
  input  wire logic [3:0]  sel_in,
  output var  psc_coef_t   coef_out
);
  // ************************************************************
  // coefficient sets, Q2.22, registered read
  // ************************************************************
  function automatic logic signed [23:0] q(input real v);
    q = 24'(longint'(v * 4194304.0));
  endfunction : q
  psc_coef_t nxt_coef;
  always_comb begin
    case (sel_in)
      4'h1: nxt_coef = '{q(0.148157329921697), q(0.013516264115488),
        q(0.013519651938257), q(0.0), q(-0.851842670078304), q(0.0),
        q(0.250031330983387), q(0.499999992148175), q(0.249968676868576),
        q(-1.749563460775225), q(0.776599376828971)};
      4'h2: nxt_coef = '{q(0.088642612609670), q(0.029638050039039),
        q(0.059333280736160), q(0.029695285913601), q(-1.422792640957290),
        q(0.511435253566960), q(0.250241278804809), q(0.499999767379068),
        q(0.249758953816089), q(-1.503329908017845), q(0.621996524706640)};
      4'h3: nxt_coef = '{q(0.129604264748411), q(0.043719804402508),
        q(0.087543281056143), q(0.043823599710731), q(-1.300502656562698),
        q(0.430106921311110), q(0.250296586927511), q(0.499999648540934),
        q(0.249703764531484), q(-1.379959571988366), q(0.555046257157745)};
      default: nxt_coef = '{q(0.017940729763385), q(0.25), q(0.5), q(0.25),
        q(-1.763648824568436), q(0.781589554331821), q(1.0), q(0.0), q(0.0),
        q(0.0), q(0.0)};
    endcase
  end
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      coef_out <= '0;
    end else begin
      coef_out <= nxt_coef;
    end
  end
endmodule : psc_coef_rom
`default_nettype wire

// [hdl/psc_signal_chain.sv]
`timescale 1ns/1ps
`default_nettype none
`include "psc_defs.svh"
module psc_signal_chain
  import psc_pkg::*;
#(
  parameter int DECIM    = `PSC_DECIM,
  parameter int BIT_CYC  = `PSC_BIT_CYCLES
)(
  input  wire logic                ref_clk_in,
  input  wire logic                rst_n_in,
  input  wire logic                mod_bit_in,
  input  wire logic signed [15:0]  temp_in,
  input  wire logic signed [15:0]  ambient_temp_reference_in,
  input  wire psc_trim_t           trim_in,
  input  wire psc_user_t           user_dsp_config_one_in,
  input  wire logic                ready_in,
  output logic                     valid_out,
  output logic signed [31:0]       data_out,
  output logic signed [22:0]       sinc_out
);
  // ************************************************************
  // reset release
  // ************************************************************
  logic rst_s1_ff, rst_s2_ff;
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rst_s1_ff <= 1'b0;
      rst_s2_ff <= 1'b0;
    end else begin
      rst_s1_ff <= 1'b1;
      rst_s2_ff <= rst_s1_ff;
    end
  end
  wire logic rst_n = rst_s2_ff;

  function automatic logic signed [31:0] qmul(input logic signed [31:0] a,
                                               input logic signed [31:0] b);
    logic signed [63:0] p;
    p = 64'(a) * 64'(b);
    qmul = p[`PSC_COEF_FRAC+31:`PSC_COEF_FRAC];
  endfunction : qmul

  // ************************************************************
  // bit tick and sinc3 decimator
  // ************************************************************
  logic [7:0]         tick_cnt_ff;
  logic               bit_tick;
  logic [5:0]         dec_cnt_ff;
  logic signed [23:0] i1_ff, i2_ff, i3_ff, c1_ff, c2_ff, c3_ff;
  logic signed [23:0] cd1, cd2, cd3;
  logic               dec_tick_ff;
  assign bit_tick = (tick_cnt_ff == 8'(BIT_CYC - 1));
  always_ff @(posedge ref_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      tick_cnt_ff <= 8'h00;
    end else begin
      tick_cnt_ff <= bit_tick ? 8'h00 : tick_cnt_ff + 8'h01;
    end
  end
  always_ff @(posedge ref_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      i1_ff <= '0; i2_ff <= '0; i3_ff <= '0; dec_cnt_ff <= '0;
    end else if (bit_tick) begin
      i1_ff <= i1_ff + (mod_bit_in ? 24'sh00_0001 : -24'sh00_0001);
      i2_ff <= i2_ff + i1_ff;
      i3_ff <= i3_ff + i2_ff;
      dec_cnt_ff <= (dec_cnt_ff == 6'(DECIM - 1)) ? 6'h00 : dec_cnt_ff + 6'h01;
    end
  end
  assign cd1 = i3_ff - c1_ff;
  assign cd2 = cd1 - c2_ff;
  assign cd3 = cd2 - c3_ff;
  always_ff @(posedge ref_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      c1_ff <= '0; c2_ff <= '0; c3_ff <= '0;
      sinc_out <= '0; dec_tick_ff <= 1'b0;
    end else begin
      dec_tick_ff <= bit_tick && dec_cnt_ff == 6'(DECIM - 1);
      if (bit_tick && dec_cnt_ff == 6'(DECIM - 1)) begin
        c1_ff <= i3_ff; c2_ff <= cd1; c3_ff <= cd2;
        sinc_out <= cd3[22:0];
      end
    end
  end

  // ************************************************************
  // sequencer: trim, lowpass, user adjust
  // ************************************************************
  psc_coef_t          cf;
  psc_state_t         st_ff;
  logic signed [31:0] x, dt, trim_ff, y1, y2;
  logic signed [31:0] s1a_ff, s1b_ff, s2a_ff, s2b_ff, lp_ff;
  logic               wr_valid;
  logic               wr_ready;
  psc_coef_rom u_rom (
    .ref_clk_in (ref_clk_in),
    .rst_n_in   (rst_n),
    .sel_in     (user_dsp_config_one_in.lowpass_coeff_select),
    .coef_out   (cf)
  );
  assign x  = 32'(sinc_out) <<< 8;
  assign dt = 32'(temp_in - ambient_temp_reference_in);
  always_ff @(posedge ref_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      st_ff <= PSC_IDLE;
    end else begin
      case (st_ff)
        PSC_IDLE: st_ff <= dec_tick_ff ? PSC_TRIM : PSC_IDLE;
        PSC_TRIM: st_ff <= PSC_LPF;
        PSC_LPF:  st_ff <= PSC_OUT;
        PSC_OUT:  st_ff <= wr_ready ? PSC_IDLE : PSC_OUT;
        default:  st_ff <= PSC_IDLE;
      endcase
    end
  end
  always_ff @(posedge ref_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      trim_ff <= '0;
    end else if (st_ff == PSC_TRIM) begin
      trim_ff <= trim_in.p0 + qmul(trim_in.pp, x)
               + qmul(trim_in.pppp, qmul(x, x))
               + qmul(trim_in.ppp, qmul(x, qmul(x, x)))
               + qmul(trim_in.pt, dt) + qmul(trim_in.ptt, qmul(dt, dt))
               + qmul(trim_in.ppt, qmul(x, dt));
    end
  end
  // direct form II transposed sections
  assign y1 = qmul(32'(cf.n1), qmul(32'(cf.a0), trim_ff)) + s1a_ff;
  assign y2 = qmul(32'(cf.m1), y1) + s2a_ff;
  always_ff @(posedge ref_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      s1a_ff <= '0; s1b_ff <= '0; s2a_ff <= '0; s2b_ff <= '0; lp_ff <= '0;
    end else if (st_ff == PSC_LPF) begin
      s1a_ff <= qmul(32'(cf.n2), qmul(32'(cf.a0), trim_ff))
              - qmul(32'(cf.d2), y1) + s1b_ff;
      s1b_ff <= qmul(32'(cf.n3), qmul(32'(cf.a0), trim_ff))
              - qmul(32'(cf.d3), y1);
      s2a_ff <= qmul(32'(cf.m2), y1) - qmul(32'(cf.e2), y2) + s2b_ff;
      s2b_ff <= qmul(32'(cf.m3), y1) - qmul(32'(cf.e3), y2);
      lp_ff  <= y2;
    end
  end
  assign wr_valid = (st_ff == PSC_OUT);

  // ************************************************************
  // two-entry output buffer
  // ************************************************************
  logic signed [31:0] buf_ff [2];
  logic [1:0]         cnt_ff;
  logic               rd_ptr_ff, wr_ptr_ff;
  logic signed [31:0] adj;
  assign adj = qmul(user_dsp_config_one_in.gain,
                    lp_ff + user_dsp_config_one_in.ofs);
  assign wr_ready  = (cnt_ff != 2'd2);
  assign valid_out = (cnt_ff != 2'd0);
  assign data_out  = buf_ff[rd_ptr_ff];
  always_ff @(posedge ref_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      buf_ff[0] <= '0; buf_ff[1] <= '0;
      cnt_ff <= 2'd0; rd_ptr_ff <= 1'b0; wr_ptr_ff <= 1'b0;
    end else begin
      if (wr_valid && wr_ready) begin
        buf_ff[wr_ptr_ff] <= adj;
        wr_ptr_ff <= ~wr_ptr_ff;
      end
      if (valid_out && ready_in) rd_ptr_ff <= ~rd_ptr_ff;
      cnt_ff <= cnt_ff + 2'(wr_valid && wr_ready)
                       - 2'(valid_out && ready_in);
    end
  end

  // ************************************************************
  // checks
  // ************************************************************
  sequence s_dec_done;
    bit_tick && dec_cnt_ff == 6'(DECIM - 1);
  endsequence
  a_sinc_rate: assert property (@(posedge ref_clk_in) disable iff (!rst_n)
    s_dec_done |=> dec_tick_ff) else $error("decimation tick missing");
  a_trim_after: assert property (@(posedge ref_clk_in) disable iff (!rst_n)
    dec_tick_ff && st_ff == PSC_IDLE |=> st_ff == PSC_TRIM)
    else $error("trim not started");
  a_lpf_follow: assert property (@(posedge ref_clk_in) disable iff (!rst_n)
    st_ff == PSC_TRIM |=> st_ff == PSC_LPF) else $error("lpf skipped");
  a_tick_period: assert property (@(posedge ref_clk_in) disable iff (!rst_n)
    bit_tick |=> !bit_tick) else $error("bit tick too fast");
  a_buf_limit: assert property (@(posedge ref_clk_in) disable iff (!rst_n)
    st_ff == PSC_OUT && !wr_ready |=> st_ff == PSC_OUT)
    else $error("result lost while buffer full");
  a_dt_value: assert property (@(posedge ref_clk_in) disable iff (!rst_n)
    temp_in == ambient_temp_reference_in |-> dt == 32'sh0000_0000)
    else $error("temp deviation wrong");
  a_reset_zero: assert property (@(posedge ref_clk_in)
    $rose(rst_n) |-> i1_ff == 0 && s1a_ff == 0) else $error("not cleared");
  a_out_hold: assert property (@(posedge ref_clk_in) disable iff (!rst_n)
    valid_out && !ready_in |=> valid_out && $stable(data_out))
    else $error("output dropped");
  a_trim_load: assert property (@(posedge ref_clk_in) disable iff (!rst_n)
    st_ff != PSC_TRIM |=> $stable(trim_ff))
    else $error("trim changed outside trim step");
  a_sel_rom: assert property (@(posedge ref_clk_in) disable iff (!rst_n)
    $stable(user_dsp_config_one_in.lowpass_coeff_select) && $past(rst_n)
    |=> $stable(cf))
    else $error("coefficients changed without select");
endmodule : psc_signal_chain
`default_nettype wire

// [testbench/psc_mod_model.sv]
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// one-bit modulator stream model
// ****************************************
module psc_mod_model #(
  parameter int BIT_CYC = 4
)(
  input  wire logic       ref_clk_in,
  input  wire logic       rst_n_in,
  input  wire logic [1:0] mode_in,
  output var  logic       bit_out
);
  int   cnt_ff;
  logic alt_ff;
  // one new bit per bit period, changed just after an edge
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cnt_ff  <= 0;
      alt_ff  <= 1'b0;
      bit_out <= 1'b0;
    end else if (cnt_ff == BIT_CYC - 1) begin
      cnt_ff <= 0;
      alt_ff <= ~alt_ff;
      case (mode_in)
        2'd0:    bit_out <= 1'b0;
        2'd1:    bit_out <= 1'b1;
        default: bit_out <= alt_ff;
      endcase
    end else begin
      cnt_ff <= cnt_ff + 1;
    end
  end
endmodule : psc_mod_model
`default_nettype wire

// [testbench/pressure_dsp_signal_chain_tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
module pressure_dsp_signal_chain_tb_top;
  import psc_pkg::*;
  localparam int BC  = 4;
  localparam int PER = 48 * BC;
  logic                clk = 0, rst_n = 0, rdy = 1;
  logic [1:0]          mode = 2'd0;
  logic signed [15:0]  temp = 16'sh0000, tref = 16'sh0000;
  psc_trim_t           trim = '0;
  psc_user_t           usr = '0;
  wire logic           mbit;
  logic                vld;
  logic signed [31:0]  dout;
  logic signed [22:0]  sinc;
  int                  bad_count = 0, n_checks = 0, cyc = 0;
  logic [31:0]         wq[$], sq[$];
  int                  tq[$];
  logic [31:0]         ref0[8];
  always #5 clk = ~clk;
  psc_mod_model #(.BIT_CYC(BC)) u_mod (.ref_clk_in(clk), .rst_n_in(rst_n),
    .mode_in(mode), .bit_out(mbit));
  psc_signal_chain #(.BIT_CYC(BC)) u_dut (.ref_clk_in(clk), .rst_n_in(rst_n),
    .mod_bit_in(mbit), .temp_in(temp), .ambient_temp_reference_in(tref),
    .trim_in(trim), .user_dsp_config_one_in(usr), .ready_in(rdy),
    .valid_out(vld), .data_out(dout), .sinc_out(sinc));
  // ****************************************
  // popped word monitor
  // ****************************************
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (vld === 1'b1 && rdy === 1'b1) begin
      wq.push_back(dout);
      sq.push_back({9'h0, sinc});
      tq.push_back(cyc);
    end
  end
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task rst(input logic [1:0] m, input psc_trim_t t, input psc_user_t u);
    @(posedge clk);
    rst_n <= 1'b0;
    mode  <= m;
    trim  <= t;
    usr   <= u;
    repeat (6) @(posedge clk);
    chk(32'(vld), 32'h0);
    chk(dout, 32'h0);
    chk(32'(sinc), 32'h0);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    wq.delete();
    sq.delete();
    tq.delete();
  endtask : rst
  task get(input int n);
    int k;
    k = 0;
    while (wq.size() < n && k < n * PER + 400) begin
      @(posedge clk);
      k++;
    end
    chk(wq.size(), n);
  endtask : get
  // ****************************************
  // scenarios
  // ****************************************
  task t_offset();
    rst(2'd1, '0, '{32'h0001_2345, 32'h0040_0000, 4'h0});
    get(4);
    foreach (wq[i]) chk(wq[i], 32'h0001_2345);
    chk(tq[3] - tq[2], PER);
  endtask : t_offset
  task t_temp();
    temp <= 16'sh4000;
    tref <= 16'sh4000;
    rst(2'd2, '{pt: 32'h0040_0000, default: 32'h0},
        '{32'h0000_0100, 32'h0040_0000, 4'h0});
    get(3);
    foreach (wq[i]) chk(wq[i], 32'h0000_0100);
    temp <= 16'sh5000;
    get(6);
    chk(wq[5] !== 32'h0000_0100, 1);
  endtask : t_temp
  task t_sinc();
    logic [31:0] z;
    rst(2'd0, '0, '0);
    get(6);
    chk(sq[5], sq[4]);
    chk(sq[5], 32'h007E_5000);
    z = sq[5];
    rst(2'd1, '0, '0);
    get(6);
    chk(sq[5], sq[4]);
    chk(sq[5], 32'h0001_B000);
    chk(sq[5] !== z, 1);
  endtask : t_sinc
  task t_select();
    int   sels[5];
    logic diff;
    sels = '{0, 12, 1, 2, 3};
    foreach (sels[j]) begin
      rst(2'd1, '{pp: 32'h0040_0000, default: 32'h0},
          '{32'h0, 32'h0040_0000, 4'(sels[j])});
      get(8);
      diff = 1'b0;
      foreach (ref0[i]) begin
        if (j == 0) ref0[i] = wq[i];
        else if (wq[i] !== ref0[i]) diff = 1'b1;
      end
      if (j > 0) chk(diff, (j > 1));
    end
  endtask : t_select
  task t_stall();
    logic [31:0] d0;
    @(posedge clk);
    rdy <= 1'b0;
    repeat (3 * PER) @(posedge clk);
    chk(vld, 1'b1);
    d0 = dout;
    repeat (PER) @(posedge clk);
    chk(dout, d0);
    wq.delete();
    tq.delete();
    rdy <= 1'b1;
    get(2);
    chk(tq[1] - tq[0], 1);
    chk(wq[0], d0);
  endtask : t_stall
  task results();
    if (bad_count == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : results
  initial begin
    #(300_000);
    bad_count++;
    results();
  end
  initial begin
    t_offset();
    t_temp();
    t_sinc();
    t_select();
    t_stall();
    results();
  end
endmodule : pressure_dsp_signal_chain_tb_top
`default_nettype wire
